/* File: hdl/ssecp_pkg.sv */
/*
  Shared constants of the serial memory command port: opcodes, status layout,
  memory geometry, timing counts and state encodings.
  Assumes a 20 MHz ref_clk on both ends.
*/
package ssecp_pkg;
  // one-byte opcodes, sent msb first
  localparam logic [7:0] OP_SET_WL = 8'h06;
  localparam logic [7:0] OP_CLR_WL = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  // status byte bit positions
  localparam int ST_LOCK = 7;
  localparam int ST_BP_HI = 3;
  localparam int ST_BP_LO = 2;
  localparam int ST_WL = 1;
  localparam int ST_BUSY = 0;
  // 8192-byte variant; the 4096-byte one would use 12
  localparam int ADDR_BITS = 13;
  localparam int MEM_DEPTH = 1 << ADDR_BITS;
  localparam int PAGE_BITS = 5;
  localparam int PAGE_BYTES = 1 << PAGE_BITS;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic NV_DELIVERED = 1'b0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // timing
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned T_WRITE_US = 5000;
  localparam int unsigned WRITE_CYCLES = T_WRITE_US * CLK_KHZ / 1000;
  localparam int unsigned T_SCK_HALF_NS = 250;
  localparam int unsigned SCK_HALF_CYCLES = (T_SCK_HALF_NS * CLK_KHZ + 999999) / 1000000;
  localparam int FIFO_DEPTH = 8;
  // device states, gray along opcode, address, read data
  typedef enum logic [3:0] {
    D_OPC = 4'h0, D_ADH = 4'h1, D_ADL = 4'h3, D_RDM = 4'h2, D_WDT = 4'h6,
    D_RDS = 4'h7, D_WST = 4'h5, D_END = 4'h4, D_IGN = 4'hC
  } ssecp_dev_state_t;
  // host states
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_LOAD = 3'h1, H_LOW = 3'h3, H_HIGH = 3'h2, H_END = 3'h6
  } ssecp_host_state_t;
endpackage

/* File: hdl/ssecp_link_if.sv */
/*
  Pin bundle between host end and memory end.
  Assumes a pull-up on the data-out wire: it reads one while undriven.
*/
`timescale 1ns/1ps
`default_nettype none
interface ssecp_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic so;
  logic so_oe_n;
  wire so_line;
  // resolved level of the shared output wire
  assign so_line = so_oe_n ? 1'b1 : so;
  modport device (input cs_n, input sck, input si, input hold_n, output so, output so_oe_n);
  modport host (output cs_n, output sck, output si, output hold_n, input so_line);
endinterface
`default_nettype wire

/* File: hdl/ssecp_device.sv */
/*
  Memory end of the serial command port: pin front end, opcode decoder,
  sequential read, status access, page buffer and timed programming.
  Assumes link pins arrive asynchronously; edges seen at least 4 cycles apart.
*/
// How it works
// - select high: deselected, output floated
// - standby when deselected and not programming
// - host opens every frame with opcode
// - input bits taken on clock rising edges
// - output bit changes only on falling edges
// - pause floats output, freezes transfer state
// - host holds select low through pause
// - delivered memory bytes read all ones
// - delivered lock and protect bits zero
// - everything shifted most significant bit first
// - unknown opcode: ignore rest of frame
// - one-byte opcodes for latch and write
// - status read repeats status byte
// - status write takes exactly one byte
// - read: address, data, then next address
// - upper address bits are ignored
// - read address wraps to zero
// - writes refused unless write latch set
// - status byte bit layout
// - busy flag set during programming
`timescale 1ns/1ps
`default_nettype none
module ssecp_device
  import ssecp_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  ssecp_link_if.device link,
  output logic standby,
  output logic program_active
);
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic sck_d_reg;
  logic cs_d_reg;
  ssecp_dev_state_t state_reg;
  logic [2:0] bit_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] op_reg;
  logic [7:0] addr_hi_reg;
  logic [ADDR_BITS-1:0] addr_reg;
  logic [PAGE_BITS-1:0] start_off_reg;
  logic [PAGE_BITS:0] pg_cnt_reg;
  logic [7:0] stat_in_reg;
  logic so_reg;
  logic so_oe_n_reg;
  logic standby_reg;
  logic wl_reg;
  logic busy_reg;
  logic lock_reg;
  logic bp_hi_reg;
  logic bp_lo_reg;
  logic is_stat_reg;
  logic [16:0] timer_reg;
  logic [PAGE_BITS:0] commit_reg;
  logic [7:0] mem [MEM_DEPTH] = '{default: ERASED_BYTE}; // delivered erased
  logic [7:0] pg_buf [PAGE_BYTES];

  // opcode decode; refused or unknown opcodes park the frame
  function automatic ssecp_dev_state_t op_target(input logic [7:0] op, input logic wl,
                                                 input logic busy);
    ssecp_dev_state_t t;
    t = D_IGN;
    case (op)
      OP_SET_WL: t = D_END;
      OP_CLR_WL: t = D_END;
      OP_STAT_RD: t = D_RDS;
      OP_STAT_WR: t = (wl && !busy) ? D_WST : D_IGN;
      OP_READ: t = busy ? D_IGN : D_ADH;
      OP_WRITE: t = (wl && !busy) ? D_ADH : D_IGN;
      default: t = D_IGN;
    endcase
    return t;
  endfunction

  // next sequential address; as wide as the array, so the last one wraps to zero
  function automatic logic [ADDR_BITS-1:0] addr_step(input logic [ADDR_BITS-1:0] a);
    return a + 1'b1;
  endfunction

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_reg <= 4'h9; // pin idle levels, so no false edge follows reset
      sync2_reg <= 4'h9;
      sck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {link.cs_n, link.sck, link.si, link.hold_n};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sync2_reg[2];
      cs_d_reg <= sync2_reg[3];
    end
  end

  // edges are found on the synchronised clock, so idle level does not matter
  wire cs_n_s = sync2_reg[3];
  wire sck_s = sync2_reg[2];
  wire si_s = sync2_reg[1];
  wire hold_n_s = sync2_reg[0];
  wire rise = sck_s & ~sck_d_reg;
  wire fall = ~sck_s & sck_d_reg;
  wire cs_rise = cs_n_s & ~cs_d_reg;
  wire live = ~cs_n_s & hold_n_s;
  wire take = live & rise;
  wire shift_out = live & fall;
  wire [7:0] rx_next = {rx_reg[6:0], si_s};
  wire byte_done = take & (bit_reg == BIT_LAST);
  wire [15:0] addr_full = {addr_hi_reg, rx_next};
  wire [ADDR_BITS-1:0] addr_in = addr_full[ADDR_BITS-1:0];
  wire [ADDR_BITS-1:0] addr_inc = addr_step(addr_reg);
  wire [7:0] status_byte = {lock_reg, 3'h0, bp_hi_reg, bp_lo_reg, wl_reg, busy_reg};
  wire aligned_end = cs_rise & (bit_reg == 3'h0);
  wire go_set = aligned_end & (state_reg == D_END) & (op_reg == OP_SET_WL);
  wire go_clr = aligned_end & (state_reg == D_END) & (op_reg == OP_CLR_WL);
  wire go_stat = aligned_end & (state_reg == D_END) & (op_reg == OP_STAT_WR);
  wire go_mem = aligned_end & (state_reg == D_WDT) & (pg_cnt_reg != '0);
  wire [PAGE_BITS-1:0] wr_off = start_off_reg + pg_cnt_reg[PAGE_BITS-1:0];
  wire [PAGE_BITS-1:0] cm_off = start_off_reg + commit_reg[PAGE_BITS-1:0];
  wire [ADDR_BITS-1:0] cm_addr = {addr_reg[ADDR_BITS-1:PAGE_BITS], cm_off};
  wire reading = (state_reg == D_RDM) | (state_reg == D_RDS);
  wire [16:0] timer_last = 17'(WRITE_CYC - 1);

  // frame sequencer; select high restarts at the opcode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= D_OPC;
      bit_reg <= 3'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      op_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      addr_reg <= '0;
      start_off_reg <= '0;
      pg_cnt_reg <= '0;
      stat_in_reg <= 8'h00;
      so_reg <= 1'b0;
    end else if (cs_n_s) begin
      state_reg <= D_OPC;
      bit_reg <= 3'h0;
    end else if (take) begin
      rx_reg <= rx_next;
      bit_reg <= bit_reg + 3'h1;
      if (state_reg == D_END) begin
        state_reg <= D_IGN; // extra clocks cancel a latched command
      end else if (byte_done) begin
        case (state_reg)
          D_OPC: begin
            op_reg <= rx_next;
            state_reg <= op_target(rx_next, wl_reg, busy_reg);
            tx_reg <= status_byte;
          end
          D_ADH: begin
            addr_hi_reg <= rx_next;
            state_reg <= D_ADL;
          end
          D_ADL: begin
            addr_reg <= (op_reg == OP_READ) ? addr_step(addr_in) : addr_in;
            tx_reg <= mem[addr_in];
            start_off_reg <= addr_in[PAGE_BITS-1:0];
            pg_cnt_reg <= '0;
            state_reg <= (op_reg == OP_READ) ? D_RDM : D_WDT;
          end
          D_RDM: begin
            tx_reg <= mem[addr_reg];
            addr_reg <= addr_inc;
          end
          D_RDS: tx_reg <= status_byte;
          D_WST: begin
            stat_in_reg <= rx_next;
            state_reg <= D_END;
          end
          D_WDT: begin
            // a page overrun writes every further byte over the first one, as the count stops at a full page
            pg_buf[wr_off] <= rx_next;
            if (pg_cnt_reg != PAGE_BYTES[PAGE_BITS:0]) begin
              pg_cnt_reg <= pg_cnt_reg + 1'b1;
            end
          end
          default: state_reg <= state_reg;
        endcase
      end
    end else if (shift_out) begin
      so_reg <= tx_reg[7];
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // write latch, programming timer and nonvolatile status bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wl_reg <= 1'b0;
      busy_reg <= 1'b0;
      lock_reg <= NV_DELIVERED;
      bp_hi_reg <= NV_DELIVERED;
      bp_lo_reg <= NV_DELIVERED;
      is_stat_reg <= 1'b0;
      timer_reg <= '0;
      commit_reg <= '0;
    end else begin
      if (go_set) begin
        wl_reg <= 1'b1;
      end
      if (go_clr) begin
        wl_reg <= 1'b0;
      end
      if (go_stat | go_mem) begin
        busy_reg <= 1'b1;
        timer_reg <= '0;
        commit_reg <= '0;
        is_stat_reg <= go_stat;
      end else if (busy_reg) begin
        timer_reg <= timer_reg + 17'h1;
        // page bytes land one per cycle, well inside the write time
        if (!is_stat_reg && commit_reg < pg_cnt_reg) begin
          mem[cm_addr] <= pg_buf[cm_off]; // buffer is kept at page offsets
          commit_reg <= commit_reg + 1'b1;
        end
        if (timer_reg == timer_last) begin
          busy_reg <= 1'b0;
          wl_reg <= 1'b0;
          if (is_stat_reg) begin
            lock_reg <= stat_in_reg[ST_LOCK];
            bp_hi_reg <= stat_in_reg[ST_BP_HI];
            bp_lo_reg <= stat_in_reg[ST_BP_LO];
          end
        end
      end
    end
  end

  // registered pin and status outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      so_oe_n_reg <= 1'b1;
      standby_reg <= 1'b1;
    end else begin
      so_oe_n_reg <= ~(live & reading);
      standby_reg <= cs_n_s & ~busy_reg;
    end
  end

  assign link.so = so_reg;
  assign link.so_oe_n = so_oe_n_reg;
  assign standby = standby_reg;
  assign program_active = busy_reg;
endmodule
`default_nettype wire

/* File: hdl/ssecp_host.sv */
/*
  Host end of the serial command port and its write-data FIFO.
  Assumes user logic on ref_clk; it makes the link clock by division.
*/
`timescale 1ns/1ps
`default_nettype none
module ssecp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic ready_reg;
  wire [AW:0] fill = wr_reg - rd_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] wr_next = wr_reg + (AW+1)'(push);
  wire [AW:0] rd_next = rd_reg + (AW+1)'(pop);
  // ready is registered one step ahead so the port comes from a flip-flop
  assign in_ready = ready_reg;
  assign out_valid = (fill != '0);
  assign out_data = buf_mem[rd_reg[AW-1:0]];
  // extra pointer bit tells full from empty
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_reg <= '0;
      rd_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      if (push) begin
        buf_mem[wr_reg[AW-1:0]] <= in_data;
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      ready_reg <= ((wr_next - rd_next) != DEPTH[AW:0]);
    end
  end
endmodule

module ssecp_host
  import ssecp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  ssecp_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic pause_req
);
  localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYCLES - 1);
  ssecp_host_state_t state_reg;
  logic [1:0] so_sync_reg;
  logic cs_n_reg;
  logic sck_reg;
  logic si_reg;
  logic hold_n_reg;
  logic [3:0] div_reg;
  logic [2:0] bit_reg;
  logic [8:0] idx_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] op_reg;
  logic [15:0] addr_reg;
  logic [8:0] total_reg;
  logic rd_valid_reg;
  logic [7:0] rd_data_reg;
  logic end_phase_reg;
  logic cmd_ready_reg;
  logic fifo_valid;
  logic [7:0] fifo_data;

  wire has_addr = (cmd_op == OP_READ) | (cmd_op == OP_WRITE);
  wire is_write_op = (op_reg == OP_WRITE) | (op_reg == OP_STAT_WR);
  wire is_read_op = (op_reg == OP_READ) | (op_reg == OP_STAT_RD);
  wire [8:0] hdr_len = ((op_reg == OP_READ) | (op_reg == OP_WRITE)) ? 9'h003 : 9'h001;
  wire in_data = (idx_reg >= hdr_len);
  wire need_fifo = in_data & is_write_op;
  wire div_end = (div_reg == HALF_LAST);
  wire so_s = so_sync_reg[1];
  // next outgoing byte, msb first
  wire [7:0] next_byte = (idx_reg == 9'h000) ? op_reg :
                         (idx_reg == 9'h001 && hdr_len != 9'h001) ? addr_reg[15:8] :
                         (idx_reg == 9'h002 && hdr_len != 9'h001) ? addr_reg[7:0] :
                         need_fifo ? fifo_data : 8'h00;
  wire load_ok = ~pause_req & (~need_fifo | fifo_valid);
  wire fifo_pop = (state_reg == H_LOAD) & load_ok & need_fifo;

  // data stalls the link when user logic falls behind
  ssecp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) ssecp_fifo_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // data-out pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      so_sync_reg <= 2'h3;
    end else begin
      so_sync_reg <= {so_sync_reg[0], link.so_line};
    end
  end

  // frame engine; the clock idles low and stops while paused
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= H_IDLE;
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
      si_reg <= 1'b0;
      hold_n_reg <= 1'b1;
      div_reg <= 4'h0;
      bit_reg <= 3'h0;
      idx_reg <= 9'h000;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      op_reg <= 8'h00;
      addr_reg <= 16'h0000;
      total_reg <= 9'h000;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      end_phase_reg <= 1'b0;
      cmd_ready_reg <= 1'b1;
    end else begin
      rd_valid_reg <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid) begin
            op_reg <= cmd_op;
            addr_reg <= cmd_addr;
            total_reg <= {1'b0, cmd_len} + (has_addr ? 9'h003 : 9'h001);
            idx_reg <= 9'h000;
            cs_n_reg <= 1'b0;
            cmd_ready_reg <= 1'b0;
            state_reg <= H_LOAD;
          end
        end
        H_LOAD: begin
          // pause moves only here or in the low phase, clock is low
          hold_n_reg <= ~pause_req;
          if (load_ok) begin
            tx_reg <= next_byte;
            si_reg <= next_byte[7];
            bit_reg <= 3'h0;
            div_reg <= 4'h0;
            state_reg <= H_LOW;
          end
        end
        H_LOW: begin
          hold_n_reg <= ~pause_req;
          // a released pause lets one cycle pass so the clock never rises with it
          if (!pause_req && hold_n_reg) begin
            div_reg <= div_end ? 4'h0 : div_reg + 4'h1;
            if (div_end) begin
              sck_reg <= 1'b1;
              state_reg <= H_HIGH;
            end
          end
        end
        H_HIGH: begin
          div_reg <= div_end ? 4'h0 : div_reg + 4'h1;
          if (div_end) begin
            // sampling late in the high phase covers both synchroniser delays
            rx_reg <= {rx_reg[6:0], so_s};
            sck_reg <= 1'b0;
            tx_reg <= {tx_reg[6:0], 1'b0};
            si_reg <= tx_reg[6];
            bit_reg <= bit_reg + 3'h1;
            state_reg <= H_LOW;
            if (bit_reg == BIT_LAST) begin
              idx_reg <= idx_reg + 9'h001;
              rd_valid_reg <= in_data & is_read_op;
              rd_data_reg <= {rx_reg[6:0], so_s};
              end_phase_reg <= 1'b0;
              state_reg <= (idx_reg + 9'h001 == total_reg) ? H_END : H_LOAD;
            end
          end
        end
        H_END: begin
          div_reg <= div_end ? 4'h0 : div_reg + 4'h1;
          if (div_end) begin
            end_phase_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            if (end_phase_reg) begin
              state_reg <= H_IDLE;
              cmd_ready_reg <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= H_IDLE;
          cmd_ready_reg <= 1'b1;
        end
      endcase
    end
  end

  assign cmd_ready = cmd_ready_reg;
  assign link.cs_n = cs_n_reg;
  assign link.sck = sck_reg;
  assign link.si = si_reg;
  assign link.hold_n = hold_n_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
endmodule
`default_nettype wire

/* File: verification/ssecp_link_properties.sv */
/*
  Concurrent checks on the pins between host end and memory end.
  Assumes the bench hands it the link bundle signals, ref_clk and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ssecp_link_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic so_line
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // pins are synchronised inside the device, so allow six cycles of lag
  a_float_when_deselected: assert property (cs_n && $past(cs_n, 6) |-> so_oe_n)
    else $error("data out driven while deselected");
  a_drive_only_selected: assert property (!so_oe_n |-> !$past(cs_n, 6))
    else $error("data out driven without a select");
  a_float_during_pause: assert property (!hold_n && !$past(hold_n, 6) |-> so_oe_n)
    else $error("data out driven during pause");
  a_so_moves_low: assert property ($changed(so) && !so_oe_n |-> !sck)
    else $error("data out changed while link clock high");
  a_so_steady_high: assert property (!so_oe_n && sck && $past(sck) |-> $stable(so))
    else $error("data out moved during high phase");
  // the opcode byte takes at least 80 cycles, no output in the first 8 after select falls
  a_quiet_opcode: assert property ($fell(cs_n) |-> ##1 so_oe_n [*8])
    else $error("data out driven during opcode");
  a_si_steady_high: assert property (sck |-> $stable(si))
    else $error("data in moved while link clock high");
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("link clock not idle low outside frame");
  a_pause_clock_low: assert property ($changed(hold_n) |-> !sck && !$past(sck))
    else $error("pause moved while link clock high");
  a_pause_selected: assert property (!hold_n |-> !cs_n)
    else $error("pause without select");
  a_line_released: assert property (cs_n && $past(cs_n, 6) |-> so_line)
    else $error("data line not released while deselected");
endmodule
`default_nettype wire

/* File: verification/spi_serial_eeprom_command_port_tb.sv */
/*
  Self-checking bench: host end and memory end joined by the link bundle.
  Assumes 20 MHz ref_clk and a shortened programming time on the memory end.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_serial_eeprom_command_port_tb;
  import ssecp_pkg::*;
  // long enough that a status read right after a write still sees it busy
  localparam int unsigned PROG = 400;
  localparam logic [7:0] PAT [8] = '{8'hA5, 8'h3C, 8'h01, 8'h80, 8'h11, 8'h22, 8'h33, 8'h44};
  logic ref_clk, reset, cmd_valid, wr_valid, pause_req;
  logic [7:0] cmd_op, cmd_len, wr_data;
  logic [15:0] cmd_addr;
  logic cmd_ready, wr_ready, rd_valid, standby, program_active;
  logic [7:0] rd_data;
  logic [7:0] got [$];
  int n_mismatch = 0;
  int num_checks = 0;

  ssecp_link_if ssecp_link_if_i ();
  ssecp_device #(.WRITE_CYC(PROG)) ssecp_device_i (.ref_clk(ref_clk), .reset(reset),
    .link(ssecp_link_if_i.device), .standby(standby), .program_active(program_active));
  ssecp_host ssecp_host_i (.ref_clk(ref_clk), .reset(reset), .link(ssecp_link_if_i.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .pause_req(pause_req));
  ssecp_link_properties ssecp_link_properties_i (.ref_clk(ref_clk), .reset(reset),
    .cs_n(ssecp_link_if_i.cs_n), .sck(ssecp_link_if_i.sck), .si(ssecp_link_if_i.si),
    .hold_n(ssecp_link_if_i.hold_n), .so(ssecp_link_if_i.so),
    .so_oe_n(ssecp_link_if_i.so_oe_n), .so_line(ssecp_link_if_i.so_line));

  // free-running reference clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one whole frame; received bytes land in got, bounded wait for the idle
  task automatic run(input logic [7:0] op, input logic [15:0] addr, input logic [7:0] len);
    int n;
    got.delete();
    @(negedge ref_clk);
    cmd_op = op;
    cmd_addr = addr;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      if (rd_valid === 1'b1) got.push_back(rd_data);
      n++;
    end while (cmd_ready !== 1'b1 && n < 4000);
    if (cmd_ready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic push(input logic [7:0] d);
    @(negedge ref_clk);
    wr_data = d;
    wr_valid = 1'b1;
    @(negedge ref_clk);
    wr_valid = 1'b0;
  endtask

  // one status read of two bytes, compared by the caller
  task automatic status();
    run(OP_STAT_RD, 16'h0000, 8'h02);
  endtask

  // the tests need roughly 10k cycles; this cuts a hang short
  initial begin
    #3_000_000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_addr = 16'h0000;
    cmd_len = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    pause_req = 1'b0;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    check({7'h00, standby}, 8'h01);
    run(OP_STAT_RD, 16'h0000, 8'h02);
    check(got[0], 8'h00);
    check(got[1], 8'h00);
    $display("test delivered status done");
    // write without the latch must leave the erased byte
    push(8'h5A);
    run(OP_WRITE, 16'h0000, 8'h01);
    repeat (PROG + 50) @(negedge ref_clk);
    run(OP_READ, 16'h0000, 8'h01);
    check(got[0], ERASED_BYTE);
    $display("test refused write done");
    run(OP_SET_WL, 16'h0000, 8'h00);
    status();
    check(got[0], 8'h02);
    run(OP_CLR_WL, 16'h0000, 8'h00);
    status();
    check(got[0], 8'h00);
    $display("test latch done");
    // fill the buffer until it refuses, then drain it with a page write
    for (int i = 0; i < 8; i++) push(PAT[i]);
    check({7'h00, wr_ready}, 8'h00);
    run(OP_SET_WL, 16'h0000, 8'h00);
    run(OP_WRITE, 16'hE000, 8'h08);
    check({7'h00, program_active}, 8'h01);
    check({7'h00, standby}, 8'h00);
    status();
    check(got[0], 8'h03);
    repeat (PROG) @(negedge ref_clk);
    status();
    check(got[0], 8'h00);
    check({7'h00, wr_ready}, 8'h01);
    $display("test page write done");
    run(OP_READ, 16'h0000, 8'h08);
    for (int i = 0; i < 8; i++) check(got[i], PAT[i]);
    run(OP_READ, 16'hFFFF, 8'h02);
    check(got[0], ERASED_BYTE);
    check(got[1], PAT[0]);
    $display("test sequential read done");
    // pause inside the first data byte: output floats, transfer is kept
    fork
      run(OP_READ, 16'h0001, 8'h02);
      begin
        repeat (300) @(negedge ref_clk);
        pause_req = 1'b1;
        repeat (60) @(negedge ref_clk);
        pause_req = 1'b0;
      end
    join
    check(got[0], PAT[1]);
    check(got[1], PAT[2]);
    $display("test pause done");
    // a write near the page end wraps to the page start
    push(8'h77);
    push(8'h66);
    push(8'h55);
    run(OP_SET_WL, 16'h0000, 8'h00);
    run(OP_WRITE, 16'h003E, 8'h03);
    repeat (PROG + 50) @(negedge ref_clk);
    run(OP_READ, 16'h003E, 8'h03);
    check(got[0], 8'h77);
    check(got[1], 8'h66);
    check(got[2], ERASED_BYTE);
    run(OP_READ, 16'h0020, 8'h01);
    check(got[0], 8'h55);
    $display("test page wrap done");
    // only the lock and protect bits are stored
    run(OP_SET_WL, 16'h0000, 8'h00);
    push(8'hFF);
    run(OP_STAT_WR, 16'h0000, 8'h01);
    repeat (PROG + 50) @(negedge ref_clk);
    status();
    check(got[0], 8'h8C);
    check(got[1], 8'h8C);
    $display("test status write done");
    // an unknown opcode leaves the latch alone
    run(OP_SET_WL, 16'h0000, 8'h00);
    run(8'hAB, 16'h0000, 8'h02);
    status();
    check(got[0], 8'h8E);
    $display("test unknown opcode done");
    end_sim();
  end
endmodule
`default_nettype wire
